// File: rtl/rri_cfg.svh
// timing constants of the restart interlock and reset input qualifier
`ifndef RRI_CFG_SVH
`define RRI_CFG_SVH

`define RRI_CLK_HZ 20000000
`define RRI_MIN_CLOSE_MS 500
`define RRI_MAX_CLOSE_MS 4500
`define RRI_SELFTEST_MS 40000
`define RRI_RESTART_DELAY_MS 100
`define RRI_PIN_COUNT 8
`define RRI_PIN_SEL_W 3
`define RRI_CNT_W 32

`endif

// File: rtl/rri_pkg.sv
// types of the restart interlock block
package rri_pkg;

  typedef enum logic [2:0] {
    st_selftest,
    st_wait_config,
    st_restart_delay,
    st_run,
    st_interlock,
    st_lockout
  } rri_state_t;

  typedef struct packed {
    logic safety_switching_output;
    logic interlock_indicator_lamp;
    logic restart_symbol;
    logic restartable;
    logic offline;
    logic lockout;
    logic waiting_config;
    logic defaults_load;
  } rri_status_t;

  typedef struct packed {
    rri_state_t st;
    logic [31:0] closed_cnt;
    logic [31:0] timer;
    logic wait_cfg;
    rri_status_t status;
  } rri_regs_t;

endpackage : rri_pkg

// File: rtl/rri_top.sv
// restart interlock, lockout and manual reset input qualifier
// What this block does
// RULE_01: accept closure 0.5 to 4.5 s, then release
// RULE_02: closure held too long is discarded
// RULE_03: after stop, wait for valid manual restart
// RULE_04: lockout holds until reset with fault cleared
// RULE_05: accepted reset reruns 40 s startup tests
// RULE_06: interlock is restartable only when zone clear
// RULE_07: restartable interlock lights lamp and restart symbol
// RULE_08: any configurable pin may carry reset input
// RULE_09: switch is normally open to positive supply
// RULE_10: factory reset restores defaults, restarts, awaits config
// RULE_11: manual start keeps outputs off until reset
// RULE_12: automatic start runs after restart delay
// RULE_13: closures shorter than minimum are ignored
`timescale 1ns/1ps
`include "rri_cfg.svh"

module rri_top #(
  parameter logic [31:0] MIN_CLOSE_CYC = 32'(`RRI_MIN_CLOSE_MS * (`RRI_CLK_HZ / 1000)),
  parameter logic [31:0] MAX_CLOSE_CYC = 32'(`RRI_MAX_CLOSE_MS * (`RRI_CLK_HZ / 1000)),
  parameter logic [31:0] SELFTEST_CYC = 32'(`RRI_SELFTEST_MS * (`RRI_CLK_HZ / 1000)),
  parameter logic [31:0] RESTART_DELAY_CYC = 32'(`RRI_RESTART_DELAY_MS * (`RRI_CLK_HZ / 1000))
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [`RRI_PIN_COUNT-1:0] multi_pin_in,
  input wire logic [`RRI_PIN_SEL_W-1:0] reset_pin_sel,
  input wire logic manual_start_mode,
  input wire logic zone_clear,
  input wire logic fault_active,
  input wire logic factory_reset_req,
  input wire logic config_loaded,
  output rri_pkg::rri_status_t status
);

  rri_pkg::rri_regs_t r_q;
  rri_pkg::rri_regs_t r_d;
  logic reset_in;
  logic accept;
  logic timer_done;

  // ------------------------------------------------------------
  // reset input qualification
  // ------------------------------------------------------------
  // any configurable pin can serve; the switch drives it high while closed
  assign reset_in = multi_pin_in[reset_pin_sel]; // RULE_08 RULE_09

  // release with a closed time inside the window
  assign accept = !reset_in && (r_q.closed_cnt >= MIN_CLOSE_CYC) // RULE_01 RULE_13
    && (r_q.closed_cnt <= MAX_CLOSE_CYC); // RULE_02

  function automatic logic limit_hit(input logic [31:0] cnt, input logic [31:0] lim);
    limit_hit = (cnt >= lim - 32'h0000_0001);
  endfunction : limit_hit

  always_comb begin
    r_d = r_q;
    timer_done = 1'b0;
    // counter saturates one past the maximum so an over-long hold stays rejected
    if (reset_in) begin
      if (r_q.closed_cnt <= MAX_CLOSE_CYC) begin
        r_d.closed_cnt = r_q.closed_cnt + 32'h0000_0001;
      end
    end else begin
      r_d.closed_cnt = '0;
    end
    r_d.timer = r_q.timer + 32'h0000_0001;
    // ------------------------------------------------------------
    // operating state
    // ------------------------------------------------------------
    unique case (r_q.st)
      rri_pkg::st_selftest: begin
        timer_done = limit_hit(r_q.timer, SELFTEST_CYC); // RULE_05
        if (timer_done) begin
          r_d.timer = '0;
          if (fault_active) begin
            r_d.st = rri_pkg::st_lockout;
          end else if (r_q.wait_cfg) begin
            r_d.st = rri_pkg::st_wait_config; // RULE_10
          end else if (manual_start_mode) begin
            r_d.st = rri_pkg::st_interlock; // RULE_11
          end else begin
            r_d.st = rri_pkg::st_restart_delay;
          end
        end
      end
      rri_pkg::st_wait_config: begin
        if (config_loaded) begin
          r_d.wait_cfg = 1'b0;
          r_d.timer = '0;
          r_d.st = manual_start_mode ? rri_pkg::st_interlock : rri_pkg::st_restart_delay;
        end
      end
      rri_pkg::st_restart_delay: begin
        // an object in the zone holds the delay at its start
        timer_done = limit_hit(r_q.timer, RESTART_DELAY_CYC);
        if (fault_active) begin
          r_d.st = rri_pkg::st_lockout;
        end else if (!zone_clear) begin
          r_d.timer = '0;
        end else if (timer_done) begin
          r_d.st = rri_pkg::st_run; // RULE_12
        end
      end
      rri_pkg::st_run: begin
        if (fault_active) begin
          r_d.st = rri_pkg::st_lockout;
        end else if (!zone_clear) begin
          r_d.st = rri_pkg::st_interlock; // RULE_03
        end
      end
      rri_pkg::st_interlock: begin
        // restart only from the restartable sub-state
        if (fault_active) begin
          r_d.st = rri_pkg::st_lockout;
        end else if (accept && zone_clear) begin
          r_d.st = rri_pkg::st_run; // RULE_03 RULE_06
        end
      end
      rri_pkg::st_lockout: begin
        // a reset while the fault persists is spent without effect
        if (accept && !fault_active) begin
          r_d.st = rri_pkg::st_selftest; // RULE_04 RULE_05
          r_d.timer = '0;
        end
      end
    endcase
    if (factory_reset_req) begin
      r_d.st = rri_pkg::st_selftest; // RULE_10
      r_d.timer = '0;
      r_d.wait_cfg = 1'b1;
    end
    // ------------------------------------------------------------
    // indications, registered from the next state, zone_clear and factory_reset_req
    // ------------------------------------------------------------
    r_d.status.safety_switching_output = (r_d.st == rri_pkg::st_run); // RULE_11
    r_d.status.restartable = (r_d.st == rri_pkg::st_interlock) && zone_clear; // RULE_06
    r_d.status.interlock_indicator_lamp = r_d.status.restartable; // RULE_07
    r_d.status.restart_symbol = r_d.status.restartable; // RULE_07
    r_d.status.offline = (r_d.st == rri_pkg::st_selftest);
    r_d.status.lockout = (r_d.st == rri_pkg::st_lockout);
    r_d.status.waiting_config = (r_d.st == rri_pkg::st_wait_config);
    r_d.status.defaults_load = factory_reset_req; // RULE_10
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r_q.st <= rri_pkg::st_selftest;
      r_q.closed_cnt <= '0;
      r_q.timer <= '0;
      r_q.wait_cfg <= 1'b0;
      r_q.status <= '0;
      r_q.status.offline <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  assign status = r_q.status;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  too_long_a: assert property (r_q.st == rri_pkg::st_interlock && !reset_in // RULE_02
    && r_q.closed_cnt > MAX_CLOSE_CYC && !fault_active && !factory_reset_req |=> r_q.st == rri_pkg::st_interlock)
    else $error("over-long closure accepted");
  too_short_a: assert property (r_q.st == rri_pkg::st_interlock && !reset_in && r_q.closed_cnt != 0 // RULE_13
    && r_q.closed_cnt < MIN_CLOSE_CYC && !fault_active && !factory_reset_req |=> r_q.st == rri_pkg::st_interlock)
    else $error("short closure accepted");
  window_accept_a: assert property ($fell(reset_in) && $past(r_q.closed_cnt) >= MIN_CLOSE_CYC - 1 // RULE_01
    && $past(r_q.closed_cnt) < MAX_CLOSE_CYC |-> accept)
    else $error("valid closure not accepted");
  interlock_hold_a: assert property (r_q.st == rri_pkg::st_interlock && !accept && !fault_active // RULE_03
    && !factory_reset_req |=> r_q.st == rri_pkg::st_interlock && !status.safety_switching_output)
    else $error("interlock left without restart");
  lockout_hold_a: assert property (r_q.st == rri_pkg::st_lockout && !(accept && !fault_active) // RULE_04
    && !factory_reset_req |=> r_q.st == rri_pkg::st_lockout && status.lockout)
    else $error("lockout left without reset");
  reset_selftest_a: assert property (r_q.st == rri_pkg::st_lockout && accept && !fault_active // RULE_05
    && !factory_reset_req |=> r_q.st == rri_pkg::st_selftest && r_q.timer == 0 ##1 status.offline)
    else $error("accepted reset did not start tests");
  lamp_restartable_a: assert property (status.interlock_indicator_lamp |-> r_q.st == rri_pkg::st_interlock // RULE_07
    && $past(zone_clear) && status.restart_symbol)
    else $error("lamp lit outside restartable interlock");
  manual_power_a: assert property (r_q.st == rri_pkg::st_selftest && timer_done && manual_start_mode // RULE_11
    && !fault_active && !r_q.wait_cfg && !factory_reset_req |=> r_q.st == rri_pkg::st_interlock
    && !status.safety_switching_output)
    else $error("manual start did not hold outputs off");
  auto_start_a: assert property (r_q.st == rri_pkg::st_restart_delay && timer_done && zone_clear // RULE_12
    && !fault_active && !factory_reset_req |=> status.safety_switching_output)
    else $error("automatic start did not switch on");
  restart_direct_a: assert property (r_q.st == rri_pkg::st_interlock && accept && zone_clear // RULE_03
    && !fault_active && !factory_reset_req |=> r_q.st == rri_pkg::st_run && status.safety_switching_output)
    else $error("valid restart did not reach run");
  stop_interlock_a: assert property (r_q.st == rri_pkg::st_run && !zone_clear && !fault_active // RULE_03
    && !factory_reset_req |=> r_q.st == rri_pkg::st_interlock && !status.safety_switching_output)
    else $error("stop did not enter interlock");
  zone_blocked_a: assert property (r_q.st == rri_pkg::st_interlock && !zone_clear // RULE_06
    |=> !status.restartable && !status.interlock_indicator_lamp)
    else $error("restartable with object present");
  lamp_on_a: assert property (r_q.st == rri_pkg::st_interlock && zone_clear && !accept && !fault_active // RULE_07
    && !factory_reset_req |=> status.restartable && status.interlock_indicator_lamp && status.restart_symbol)
    else $error("restartable interlock not shown");
  selftest_span_a: assert property (r_q.st == rri_pkg::st_selftest // RULE_05
    && r_q.timer < SELFTEST_CYC - 32'h0000_0001 && !factory_reset_req |=> r_q.st == rri_pkg::st_selftest && status.offline)
    else $error("startup tests cut short");
  closure_count_a: assert property (reset_in && r_q.closed_cnt <= MAX_CLOSE_CYC // RULE_13
    |=> r_q.closed_cnt == $past(r_q.closed_cnt) + 32'h0000_0001)
    else $error("closure time not counted");
  delay_hold_a: assert property (r_q.st == rri_pkg::st_restart_delay && !zone_clear && !fault_active // RULE_12
    && !factory_reset_req |=> r_q.st == rri_pkg::st_restart_delay && r_q.timer == 0)
    else $error("restart delay ran with object present");
  lockout_no_run_a: assert property (r_q.st == rri_pkg::st_lockout // RULE_04
    |=> r_q.st != rri_pkg::st_run && !status.safety_switching_output)
    else $error("lockout went straight to run");
  factory_a: assert property (factory_reset_req |=> status.defaults_load && r_q.wait_cfg // RULE_10
    && r_q.st == rri_pkg::st_selftest)
    else $error("factory reset not carried out");

endmodule : rri_top

// File: test/rri_switch_model.sv
// person-operated normally open reset switch
`timescale 1ns/1ps
module rri_switch_model (
  input wire logic ref_clk,
  output logic contact
);
  // open contact reads low, the input side pulls it down
  initial contact = 1'b0;
  task automatic press(input int unsigned cycles);
    @(posedge ref_clk);
    contact <= 1'b1;
    repeat (cycles) @(posedge ref_clk);
    contact <= 1'b0;
  endtask : press
endmodule : rri_switch_model

// File: test/rri_top_bench.sv
// self-checking bench of the restart interlock block
`timescale 1ns/1ps
module rri_top_bench;
  localparam int MINC = 4;
  localparam int MAXC = 20;
  localparam int TEST = 10;
  localparam int DLY = 6;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] multi_pin_in;
  logic [2:0] reset_pin_sel = 3'h0;
  logic manual_start_mode = 1'b1;
  logic zone_clear = 1'b1;
  logic fault_active = 1'b0;
  logic factory_reset_req = 1'b0;
  logic config_loaded = 1'b0;
  logic contact;
  rri_pkg::rri_status_t status;
  int fails = 0;
  int num_checks = 0;
  always #25 ref_clk = ~ref_clk;
  // only the selected pin carries the switch, the rest stay open
  always_comb begin
    multi_pin_in = 8'h00;
    multi_pin_in[reset_pin_sel] = contact;
  end
  rri_top #(.MIN_CLOSE_CYC(32'(MINC)), .MAX_CLOSE_CYC(32'(MAXC)), .SELFTEST_CYC(32'(TEST)),
    .RESTART_DELAY_CYC(32'(DLY))) rri_top_i (.ref_clk(ref_clk), .reset(reset), .multi_pin_in(multi_pin_in),
    .reset_pin_sel(reset_pin_sel), .manual_start_mode(manual_start_mode), .zone_clear(zone_clear),
    .fault_active(fault_active), .factory_reset_req(factory_reset_req), .config_loaded(config_loaded),
    .status(status));
  rri_switch_model rri_switch_model_i (.ref_clk(ref_clk), .contact(contact));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] st(input logic run, lamp, offl, lock, wcfg);
    return {run, lamp, lamp, lamp, offl, lock, wcfg, 1'b0};
  endfunction : st
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // bounded wait for a status value, then compare
  task automatic wait_for(input string what, input logic [7:0] exp, input int lim);
    int i = 0;
    // first look is at a falling edge, never in the launching time step
    @(negedge ref_clk);
    while (status !== exp && i < lim) begin
      @(negedge ref_clk);
      i++;
    end
    check(what, exp, status);
  endtask : wait_for
  task automatic hold(input string what, input logic [7:0] exp);
    repeat (6) @(negedge ref_clk);
    check(what, exp, status);
  endtask : hold
  task automatic drive(input int sel, input logic z, input logic f);
    @(posedge ref_clk);
    reset_pin_sel <= 3'(sel);
    zone_clear <= z;
    fault_active <= f;
  endtask : drive
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_power_up;
    check("offline after reset", st(0, 0, 1, 0, 0), status);
    wait_for("manual start interlock", st(0, 1, 0, 0, 0), TEST + 4);
    $display("test power_up done");
  endtask : t_power_up
  task automatic t_closures;
    rri_switch_model_i.press(MINC - 1);
    hold("short closure ignored", st(0, 1, 0, 0, 0));
    rri_switch_model_i.press(MAXC + 1);
    hold("long closure ignored", st(0, 1, 0, 0, 0));
    rri_switch_model_i.press(MINC);
    wait_for("restart at minimum", st(1, 0, 0, 0, 0), 5);
    drive(0, 1'b0, 1'b0);
    wait_for("stop to interlock", st(0, 0, 0, 0, 0), 4);
    rri_switch_model_i.press(MINC);
    hold("object still present", st(0, 0, 0, 0, 0));
    drive(0, 1'b1, 1'b0);
    wait_for("restartable lamp", st(0, 1, 0, 0, 0), 4);
    rri_switch_model_i.press(MAXC);
    wait_for("restart at maximum", st(1, 0, 0, 0, 0), 5);
    $display("test closures done");
  endtask : t_closures
  task automatic t_lockout;
    drive(0, 1'b1, 1'b1);
    wait_for("lockout entered", st(0, 0, 0, 1, 0), 4);
    rri_switch_model_i.press(MINC);
    hold("lockout with fault", st(0, 0, 0, 1, 0));
    drive(0, 1'b1, 1'b0);
    hold("lockout after repair", st(0, 0, 0, 1, 0));
    rri_switch_model_i.press(MINC);
    wait_for("reset reruns tests", st(0, 0, 1, 0, 0), 5);
    wait_for("tests end", st(0, 1, 0, 0, 0), TEST + 4);
    $display("test lockout done");
  endtask : t_lockout
  task automatic t_factory_auto;
    @(posedge ref_clk);
    manual_start_mode <= 1'b0;
    factory_reset_req <= 1'b1;
    @(posedge ref_clk);
    factory_reset_req <= 1'b0;
    wait_for("defaults pulse", st(0, 0, 1, 0, 0) | 8'h01, 3);
    wait_for("awaiting config", st(0, 0, 0, 0, 1), TEST + 4);
    @(posedge ref_clk);
    config_loaded <= 1'b1;
    @(posedge ref_clk);
    config_loaded <= 1'b0;
    wait_for("automatic start", st(1, 0, 0, 0, 0), DLY + 5);
    $display("test factory_auto done");
  endtask : t_factory_auto
  task automatic t_other_pin;
    drive(5, 1'b0, 1'b0);
    drive(5, 1'b1, 1'b0);
    wait_for("interlock on pin five", st(0, 1, 0, 0, 0), 4);
    rri_switch_model_i.press(MINC + 2);
    wait_for("restart from pin five", st(1, 0, 0, 0, 0), 5);
    $display("test other_pin done");
  endtask : t_other_pin
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    t_power_up();
    t_closures();
    t_lockout();
    t_factory_auto();
    t_other_pin();
    test_done();
  end
  // the sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    fails++;
    test_done();
  end
endmodule : rri_top_bench
